/* rbm_port.sv */
// Purpose: constants and types for the rmw bit and block move datapath,
//          and the byte-wide port data and direction registers
// Assumes: one clock, asynchronous active-high reset
// Notes:   pins pass a two-flop synchroniser before any read
package rbm_pkg;
   localparam int          DATA_W         = 8;
   localparam int          ADDR_W         = 16;
   localparam logic [15:0] ROM_BASE       = 16'h0000;
   localparam logic [15:0] ROM_TOP        = 16'h7FFF;
   localparam logic [15:0] RAM_BASE       = 16'hF780;
   localparam logic [15:0] RAM_TOP        = 16'hFF7F;
   localparam logic [15:0] PORT_DATA_ADDR = 16'hFFD8;
   localparam logic [15:0] PORT_DIR_ADDR  = 16'hFFE8;
   localparam logic [7:0]  UNMAPPED_RD    = 8'hFF;
   localparam logic [7:0]  WO_READ        = 8'hFF;
   localparam logic [7:0]  BYTE_ZERO      = 8'h00;
   localparam logic [7:0]  BYTE_ONE       = 8'h01;
   localparam logic [15:0] ADDR_ONE       = 16'h0001;
   localparam logic [15:0] ADDR_ZERO      = 16'h0000;

   typedef enum logic [2:0] {
      OP_READ      = 3'b000,
      OP_WRITE     = 3'b001,
      OP_SET       = 3'b010,
      OP_CLEAR     = 3'b011,
      OP_INVERT    = 3'b100,
      OP_STC       = 3'b101,
      OP_STIC      = 3'b110,
      OP_MOVE      = 3'b111
   } rbm_op_e;

   typedef enum logic [1:0] {
      RG_MEM       = 2'b00,
      RG_PORT_DATA = 2'b01,
      RG_PORT_DIR  = 2'b10,
      RG_NONE      = 2'b11
   } rbm_region_e;

   typedef enum logic [1:0] {
      S_IDLE  = 2'b00,
      S_WAIT  = 2'b01,
      S_DATA  = 2'b10,
      S_WRITE = 2'b11
   } rbm_state_e;

   typedef struct packed {
      rbm_op_e     op;
      logic [15:0] addr;
      logic [2:0]  bit_sel;
      logic        carry;
      logic [7:0]  wdata;
      logic [7:0]  count;
      logic [15:0] src;
      logic [15:0] dst;
   } rbm_cmd_s;

   typedef struct packed {
      logic        mem_re;
      logic        mem_we;
      logic        prt_re;
      logic        prt_we;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } rbm_bus_s;

   typedef struct packed {
      rbm_state_e  state;
      rbm_cmd_s    cmd;
      rbm_bus_s    bus;
      logic [7:0]  rdata;
      logic        done;
      logic        rdy;
   } rbm_core_s;

   typedef struct packed {
      logic [7:0]  sync1;
      logic [7:0]  sync2;
      logic [7:0]  data;
      logic [7:0]  dir;
      logic [7:0]  oe_n;
      logic [7:0]  rdata;
   } rbm_port_s;

   function automatic rbm_region_e rbm_region(input logic [15:0] a);
      if (a == PORT_DATA_ADDR)
         return RG_PORT_DATA;
      else if (a == PORT_DIR_ADDR)
         return RG_PORT_DIR;
      else if ((a <= ROM_TOP) || ((a >= RAM_BASE) && (a <= RAM_TOP)))
         return RG_MEM;
      else
         return RG_NONE;
   endfunction
endpackage

`timescale 1ns/100ps
`default_nettype none
module rbm_port (
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   // register access
   input  wire logic        re_i,
   input  wire logic        we_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   output logic      [7:0]  rdata_o,
   // pins
   input  wire logic [7:0]  pin_i,
   output logic      [7:0]  pin_o,
   output logic      [7:0]  pin_oe_n_o
);
   import rbm_pkg::*;
   rbm_port_s q;
   rbm_port_s d;

   always_comb begin
      d       = q;
      d.sync1 = pin_i;
      d.sync2 = q.sync1;
      if (we_i && (rbm_region(addr_i) == RG_PORT_DATA)) begin
         d.data = wdata_i;
      end
      if (we_i && (rbm_region(addr_i) == RG_PORT_DIR)) begin
         d.dir  = wdata_i;
         d.oe_n = ~wdata_i;
      end
      if (re_i) begin
         case (rbm_region(addr_i))
            RG_PORT_DATA: d.rdata = (q.dir & q.data) | (~q.dir & q.sync2);
            RG_PORT_DIR:  d.rdata = WO_READ;
            default:      d.rdata = UNMAPPED_RD;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '{sync1: BYTE_ZERO, sync2: BYTE_ZERO, data: BYTE_ZERO,
                dir: BYTE_ZERO, oe_n: ~BYTE_ZERO, rdata: BYTE_ZERO};
      end else begin
         q <= d;
      end
   end

   assign rdata_o    = q.rdata;
   assign pin_o      = q.data;
   assign pin_oe_n_o = q.oe_n;

   chk_in_pin: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (re_i && addr_i == PORT_DATA_ADDR) |=> ((rdata_o & ~$past(q.dir)) ==
      ($past(q.sync2) & ~$past(q.dir)))) else $error("input bit not pin");
   chk_out_latch: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (re_i && addr_i == PORT_DATA_ADDR) |=> ((rdata_o & $past(q.dir)) ==
      ($past(q.data) & $past(q.dir)))) else $error("output bit not latch");
   chk_dir_ones: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (re_i && addr_i == PORT_DIR_ADDR) |=> (rdata_o == WO_READ))
      else $error("direction read not all ones");
   chk_dir_oe: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (pin_oe_n_o == ~q.dir)) else $error("enable differs from direction");
   chk_pin_data: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (we_i && addr_i == PORT_DATA_ADDR) |=> (pin_o == $past(wdata_i)))
      else $error("pin does not follow data");
endmodule
`default_nettype wire

/* rbm_core.sv */
// Purpose: byte read-modify-write bit ops, block move, plain access
// Assumes: memory answers a read one cycle after mem_re_o
// Notes:   unmapped reads return all ones
`timescale 1ns/100ps
`default_nettype none
module rbm_core (
   // clock and reset
   input  wire logic            core_clk_i,
   input  wire logic            rst_i,
   // command
   input  wire logic            cmd_valid_i,
   input  wire rbm_pkg::rbm_cmd_s cmd_i,
   output logic                 cmd_ready_o,
   output logic                 done_o,
   output logic      [7:0]      rdata_o,
   // memory bus
   output logic                 mem_re_o,
   output logic                 mem_we_o,
   output logic      [15:0]     mem_addr_o,
   output logic      [7:0]      mem_wdata_o,
   input  wire logic [7:0]      mem_rdata_i,
   // port pins
   input  wire logic [7:0]      pin_i,
   output logic      [7:0]      pin_o,
   output logic      [7:0]      pin_oe_n_o
);
   import rbm_pkg::*;
   rbm_core_s  q;
   rbm_core_s  d;
   logic [7:0] prt_rdata;
   logic [7:0] rd_byte;
   logic [7:0] mask;
   logic [7:0] mod_byte;
   logic       is_bit_op;

   rbm_port u_port (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .re_i       (q.bus.prt_re),
      .we_i       (q.bus.prt_we),
      .addr_i     (q.bus.addr),
      .wdata_i    (q.bus.wdata),
      .rdata_o    (prt_rdata),
      .pin_i      (pin_i),
      .pin_o      (pin_o),
      .pin_oe_n_o (pin_oe_n_o)
   );

   function automatic rbm_bus_s issue(input logic [15:0] a, input logic wr,
                                      input logic [7:0] wd);
      rbm_bus_s b;
      rbm_region_e r;
      r       = rbm_region(a);
      b.addr  = a;
      b.wdata = wd;
      b.mem_re = !wr && (r == RG_MEM);
      b.prt_re = !wr && (r != RG_MEM) && (r != RG_NONE);
      b.mem_we = wr && (r == RG_MEM);
      b.prt_we = wr && (r != RG_MEM) && (r != RG_NONE);
      return b;
   endfunction

   always_comb begin
      case (rbm_region(q.bus.addr))
         RG_MEM:  rd_byte = mem_rdata_i;
         RG_NONE: rd_byte = UNMAPPED_RD;
         default: rd_byte = prt_rdata;
      endcase
      mask      = BYTE_ONE << q.cmd.bit_sel;
      is_bit_op = (q.cmd.op != OP_READ) && (q.cmd.op != OP_WRITE) &&
                  (q.cmd.op != OP_MOVE);
      case (q.cmd.op)
         OP_SET:    mod_byte = rd_byte | mask;
         OP_CLEAR:  mod_byte = rd_byte & ~mask;
         OP_INVERT: mod_byte = rd_byte ^ mask;
         OP_STC:    mod_byte = q.cmd.carry ? (rd_byte | mask) : (rd_byte & ~mask);
         OP_STIC:   mod_byte = q.cmd.carry ? (rd_byte & ~mask) : (rd_byte | mask);
         default:   mod_byte = rd_byte;
      endcase
   end

   always_comb begin
      d      = q;
      d.done = 1'b0;
      d.bus.mem_re = 1'b0;
      d.bus.prt_re = 1'b0;
      d.bus.mem_we = 1'b0;
      d.bus.prt_we = 1'b0;
      case (q.state)
         S_IDLE: begin
            if (cmd_valid_i && q.rdy) begin
               d.cmd = cmd_i;
               d.rdy = 1'b0;
               case (cmd_i.op)
                  OP_WRITE: begin
                     d.bus   = issue(cmd_i.addr, 1'b1, cmd_i.wdata);
                     d.state = S_WRITE;
                  end
                  OP_MOVE: begin
                     if (cmd_i.count == BYTE_ZERO) begin
                        d.done = 1'b1;
                        d.rdy  = 1'b1;
                     end else begin
                        d.bus   = issue(cmd_i.src, 1'b0, BYTE_ZERO);
                        d.state = S_WAIT;
                     end
                  end
                  default: begin
                     d.bus   = issue(cmd_i.addr, 1'b0, BYTE_ZERO);
                     d.state = S_WAIT;
                  end
               endcase
            end
         end
         S_WAIT: begin
            d.state = S_DATA;
         end
         S_DATA: begin
            d.rdata = rd_byte;
            if (q.cmd.op == OP_READ) begin
               d.done  = 1'b1;
               d.rdy   = 1'b1;
               d.state = S_IDLE;
            end else if (q.cmd.op == OP_MOVE) begin
               d.bus       = issue(q.cmd.dst, 1'b1, rd_byte);
               d.cmd.src   = 16'(q.cmd.src + ADDR_ONE);
               d.cmd.dst   = 16'(q.cmd.dst + ADDR_ONE);
               d.cmd.count = 8'(q.cmd.count - BYTE_ONE);
               d.state     = S_WRITE;
            end else begin
               d.bus   = issue(q.cmd.addr, 1'b1, mod_byte);
               d.state = S_WRITE;
            end
         end
         S_WRITE: begin
            if ((q.cmd.op == OP_MOVE) && (q.cmd.count != BYTE_ZERO)) begin
               d.bus   = issue(q.cmd.src, 1'b0, BYTE_ZERO);
               d.state = S_WAIT;
            end else begin
               d.done  = 1'b1;
               d.rdy   = 1'b1;
               d.state = S_IDLE;
            end
         end
         default: begin
            d.state = S_IDLE;
            d.rdy   = 1'b1;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q       <= '0;
         q.state <= S_IDLE;
         q.rdy   <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign cmd_ready_o = q.rdy;
   assign done_o      = q.done;
   assign rdata_o     = q.rdata;
   assign mem_re_o    = q.bus.mem_re;
   assign mem_we_o    = q.bus.mem_we;
   assign mem_addr_o  = q.bus.addr;
   assign mem_wdata_o = q.bus.wdata;

   chk_unmapped_drop: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (q.bus.mem_we || q.bus.prt_we) |-> (rbm_region(q.bus.addr) != RG_NONE))
      else $error("write reached unmapped address");
   chk_bit_only: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (q.state == S_WRITE && is_bit_op) |->
      (((q.bus.wdata ^ q.rdata) & ~mask) == BYTE_ZERO && q.bus.addr == q.cmd.addr))
      else $error("bit op changed other bits");
   chk_move_count: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (q.state == S_DATA && q.cmd.op == OP_MOVE) |=>
      (q.cmd.count == 8'($past(q.cmd.count) - BYTE_ONE)))
      else $error("move count not decremented");
   chk_move_ascend: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (q.state == S_WRITE && q.cmd.op == OP_MOVE) |->
      (q.bus.addr == 16'(q.cmd.dst - ADDR_ONE) && q.bus.wdata == q.rdata))
      else $error("move wrote wrong place");
   chk_read_latency: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (cmd_valid_i && q.rdy && cmd_i.op == OP_READ) |-> ##3 done_o)
      else $error("read not done in three cycles");
   chk_move_end: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (done_o && q.cmd.op == OP_MOVE) |-> (q.cmd.count == BYTE_ZERO))
      else $error("move ended with bytes left");

   cov_bit_op: cover property (@(posedge core_clk_i) disable iff (rst_i)
      (q.state == S_WRITE && is_bit_op && q.bus.prt_we));
   cov_move: cover property (@(posedge core_clk_i) disable iff (rst_i)
      (done_o && q.cmd.op == OP_MOVE && q.cmd.src != cmd_i.src));
   cov_unmapped: cover property (@(posedge core_clk_i) disable iff (rst_i)
      (q.state == S_DATA && rbm_region(q.bus.addr) == RG_NONE));
endmodule
`default_nettype wire

/* rbm_pkg_note.sv */
// Purpose: none
// Assumes: none
// Notes:   package lives in rbm_port.sv
`default_nettype none
`default_nettype wire

/* rbm_mem_model.sv */
// Purpose: on-chip memory as seen from the core's memory bus
// Assumes: read data is due in the cycle after the read strobe
// Notes:   outside that cycle the data lines show a changing pattern
`timescale 1ns/100ps
`default_nettype none
module rbm_mem_model (
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   // memory bus
   input  wire logic        re_i,
   input  wire logic        we_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   output logic      [7:0]  rdata_o
);
   logic [7:0] mem [logic [15:0]];

   // contents survive reset, only the data lines restart
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 8'h5A;
      end else begin
         if (we_i)
            mem[addr_i] = wdata_i;
         if (re_i)
            rdata_o <= mem.exists(addr_i) ? mem[addr_i] : ~addr_i[7:0];
         else
            rdata_o <= ~rdata_o;
      end
   end
endmodule
`default_nettype wire

/* tb_cpu_rmw_bit_and_block_move.sv */
// Purpose: self-checking bench for the bit op and block move core
// Assumes: inputs change at the falling edge
// Notes:   single-byte memory cases run from a row table, moves, port and reset by hand
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_rmw_bit_and_block_move;
   import rbm_pkg::*;
   typedef struct packed {
      rbm_op_e     op;
      logic [15:0] a;
      logic [2:0]  b;
      logic        c;
      logic [7:0]  wd;
      logic [7:0]  ex;
      logic [16:0] wn;
   } rbm_row_s;
   logic        core_clk;
   logic        rst;
   logic        cmd_valid;
   rbm_cmd_s    cmd;
   logic        cmd_ready;
   logic        done;
   logic [7:0]  rdata;
   logic        mem_re;
   logic        mem_we;
   logic [15:0] mem_addr;
   logic [7:0]  mem_wdata;
   logic [7:0]  mem_rdata;
   logic [7:0]  pin_in;
   logic [7:0]  pin_out;
   logic [7:0]  pin_oe_n;
   logic [16:0] log_q [$];
   int          fail_count = 0;
   int          total_checks = 0;
   rbm_row_s    rows [12] = '{
      '{OP_WRITE,  16'hF780, 3'h0, 1'b0, 8'hA5, 8'hA5, 17'h1},
      '{OP_SET,    16'hF780, 3'h1, 1'b0, 8'h00, 8'hA7, 17'h1},
      '{OP_CLEAR,  16'hF780, 3'h7, 1'b0, 8'h00, 8'h27, 17'h1},
      '{OP_INVERT, 16'hF780, 3'h0, 1'b0, 8'h00, 8'h26, 17'h1},
      '{OP_STC,    16'hF780, 3'h3, 1'b1, 8'h00, 8'h2E, 17'h1},
      '{OP_STIC,   16'hF780, 3'h5, 1'b1, 8'h00, 8'h0E, 17'h1},
      '{OP_STC,    16'hF780, 3'h7, 1'b0, 8'h00, 8'h0E, 17'h1},
      '{OP_STIC,   16'hF780, 3'h7, 1'b0, 8'h00, 8'h8E, 17'h1},
      '{OP_WRITE,  16'h0100, 3'h0, 1'b0, 8'h3C, 8'h3C, 17'h1},
      '{OP_WRITE,  16'hFF7F, 3'h0, 1'b0, 8'h11, 8'h11, 17'h1},
      '{OP_WRITE,  16'h9000, 3'h0, 1'b0, 8'h55, 8'hFF, 17'h0},
      '{OP_WRITE,  16'hFF80, 3'h0, 1'b0, 8'h66, 8'hFF, 17'h0}};

   rbm_core dut_u (
      .core_clk_i(core_clk), .rst_i(rst), .cmd_valid_i(cmd_valid),
      .cmd_i(cmd), .cmd_ready_o(cmd_ready), .done_o(done),
      .rdata_o(rdata), .mem_re_o(mem_re), .mem_we_o(mem_we),
      .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata),
      .mem_rdata_i(mem_rdata), .pin_i(pin_in), .pin_o(pin_out),
      .pin_oe_n_o(pin_oe_n));

   rbm_mem_model mem_u (
      .core_clk_i(core_clk), .rst_i(rst), .re_i(mem_re), .we_i(mem_we),
      .addr_i(mem_addr), .wdata_i(mem_wdata), .rdata_o(mem_rdata));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // strobe log, sampled where outputs are settled
   always @(negedge core_clk) begin
      if (mem_re === 1'b1)
         log_q.push_back({1'b0, mem_addr});
      if (mem_we === 1'b1)
         log_q.push_back({1'b1, mem_addr});
   end

   task automatic chk(input string nm, input logic [16:0] seen,
                      input logic [16:0] ex);
      total_checks++;
      if (seen !== ex) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, ex, seen);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   function automatic int lat(input rbm_op_e op, input logic [7:0] n);
      case (op)
         OP_READ:  return 3;
         OP_WRITE: return 2;
         OP_MOVE:  return 3 * int'(n) + 1;
         default:  return 4;
      endcase
   endfunction

   function automatic logic [16:0] nwr;
      nwr = '0;
      foreach (log_q[i])
         nwr = nwr + {16'h0, log_q[i][16]};
   endfunction

   // one command, latency from take to done checked
   task automatic run(input rbm_op_e op, input logic [15:0] a,
                      input logic [2:0] b, input logic c,
                      input logic [7:0] wd, input logic [7:0] n,
                      input logic [15:0] s, input logic [15:0] d);
      int k;
      int cyc;
      @(negedge core_clk);
      cmd = '{op, a, b, c, wd, n, s, d};
      cmd_valid = 1'b1;
      for (k = 0; k < 50 && cmd_ready !== 1'b1; k++)
         @(negedge core_clk);
      log_q.delete();
      @(negedge core_clk);
      cmd_valid = 1'b0;
      for (cyc = 1; cyc < 2000 && done !== 1'b1; cyc++)
         @(negedge core_clk);
      if (k == 50 || cyc == 2000) begin
         fail_count++;
         give_verdict();
      end else begin
         chk("latency", 17'(cyc), 17'(lat(op, n)));
      end
   endtask

   task automatic rd(input logic [15:0] a);
      run(OP_READ, a, 3'h0, 1'b0, 8'h00, 8'h00, 16'h0, 16'h0);
   endtask

   initial begin
      rst = 1'b1;
      cmd_valid = 1'b0;
      cmd = '0;
      pin_in = 8'h55;
      repeat (8) @(negedge core_clk);
      chk("ready", cmd_ready, 17'h1);
      chk("oe_n", pin_oe_n, 17'hFF);
      chk("pins", pin_out, 17'h0);
      rst = 1'b0;
      foreach (rows[i]) begin
         run(rows[i].op, rows[i].a, rows[i].b, rows[i].c, rows[i].wd,
             8'h00, 16'h0, 16'h0);
         chk("writes", nwr(), rows[i].wn);
         rd(rows[i].a);
         chk("byte", rdata, rows[i].ex);
      end
      for (int k = 0; k < 4; k++)
         run(OP_WRITE, 16'hF800 + 16'(k), 3'h0, 1'b0, 8'(8'h11 * (k + 1)),
             8'h00, 16'h0, 16'h0);
      run(OP_MOVE, 16'h0, 3'h0, 1'b0, 8'h00, 8'h04, 16'hF800, 16'hF900);
      chk("move strobes", 17'(log_q.size()), 17'h8);
      for (int k = 0; k < 4; k++) begin
         chk("move src", log_q[2*k], {1'b0, 16'hF800 + 16'(k)});
         chk("move dst", log_q[2*k+1], {1'b1, 16'hF900 + 16'(k)});
      end
      for (int k = 0; k < 4; k++) begin
         rd(16'hF900 + 16'(k));
         chk("moved", rdata, 17'(8'h11 * (k + 1)));
      end
      run(OP_MOVE, 16'h0, 3'h0, 1'b0, 8'h00, 8'h00, 16'hF800, 16'hFA00);
      chk("empty move", 17'(log_q.size()), 17'h0);
      run(OP_WRITE, PORT_DIR_ADDR, 3'h0, 1'b0, 8'h3F, 8'h00, 16'h0, 16'h0);
      run(OP_WRITE, PORT_DATA_ADDR, 3'h0, 1'b0, 8'h80, 8'h00, 16'h0, 16'h0);
      chk("oe_n", pin_oe_n, 17'hC0);
      chk("pins", pin_out, 17'h80);
      rd(PORT_DATA_ADDR);
      chk("port byte", rdata, 17'h40);
      rd(PORT_DIR_ADDR);
      chk("dir byte", rdata, 17'hFF);
      run(OP_SET, PORT_DATA_ADDR, 3'h0, 1'b0, 8'h00, 8'h00, 16'h0, 16'h0);
      chk("pins", pin_out, 17'h41);
      run(OP_CLEAR, PORT_DIR_ADDR, 3'h0, 1'b0, 8'h00, 8'h00, 16'h0, 16'h0);
      chk("oe_n", pin_oe_n, 17'h01);
      pin_in = 8'hAA;
      rd(PORT_DATA_ADDR);
      chk("port byte", rdata, 17'h40);
      // shadow copy edited in memory, then written whole
      run(OP_WRITE, RAM_BASE, 3'h0, 1'b0, 8'h3F, 8'h00, 16'h0, 16'h0);
      run(OP_CLEAR, RAM_BASE, 3'h0, 1'b0, 8'h00, 8'h00, 16'h0, 16'h0);
      rd(RAM_BASE);
      run(OP_WRITE, PORT_DIR_ADDR, 3'h0, 1'b0, rdata, 8'h00, 16'h0, 16'h0);
      chk("oe_n", pin_oe_n, 17'hC1);
      // reset in the middle of a move
      @(negedge core_clk);
      cmd = '{OP_MOVE, 16'h0, 3'h0, 1'b0, 8'h00, 8'h04, 16'hF800, 16'hFA00};
      cmd_valid = 1'b1;
      repeat (3) @(negedge core_clk);
      cmd_valid = 1'b0;
      rst = 1'b1;
      @(negedge core_clk);
      chk("ready", cmd_ready, 17'h1);
      chk("write strobe", mem_we, 17'h0);
      chk("oe_n", pin_oe_n, 17'hFF);
      rst = 1'b0;
      rd(16'hF901);
      chk("byte", rdata, 17'h22);
      give_verdict();
   end
endmodule
`default_nettype wire
